//--- hdl/cpl_pkg.sv
// Purpose: shared constants and types of the card password lock
// Assumes: 32-bit AXI4-Lite register bus, byte-wide data block stream
// Notes: password image is kept in a non-volatile store outside this block
package cpl_pkg;
	// register offsets (byte addresses)
	localparam int AXI_AW = 8;
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_BLKLEN = 8'h08;
	localparam logic [7:0] OFF_PWLEN = 8'h0C;
	// status and control field positions
	localparam int STAT_LOCKED_BIT = 0;
	localparam int STAT_FAIL_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	localparam int CTRL_SEL_BIT = 0;
	localparam int CTRL_TRAN_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int BLKLEN_W = 12;
	localparam logic [BLKLEN_W-1:0] BLKLEN_RST = 12'h000;
	// mode byte fields
	localparam int MODE_SET_BIT = 0;
	localparam int MODE_CLR_BIT = 1;
	localparam int MODE_LOCK_BIT = 2;
	localparam int MODE_ERASE_BIT = 3;
	localparam logic [7:0] MODE_ERASE_ONLY = 8'h08;
	// sizes of the password and the receive buffer
	localparam int PW_BYTES = 16;
	localparam int PW_BITS = 128;
	localparam int LEN_BITS = 8;
	localparam int RX_BYTES = 34;
	localparam logic [BLKLEN_W-1:0] RX_BYTES_LEN = 12'h022;
	localparam logic [BLKLEN_W-1:0] HDR_BYTES_LEN = 12'h002;
	localparam logic [BLKLEN_W-1:0] ERASE_BLK_LEN = 12'h001;
	localparam logic [LEN_BITS-1:0] PW_BYTES_LEN = 8'h10;
	localparam logic [LEN_BITS-1:0] LEN_RST = 8'h00;
	// command classes still served while locked
	localparam logic [3:0] CLASS_BASIC = 4'h0;
	localparam logic [3:0] CLASS_LOCK = 4'h7;
	// block checksum
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [PW_BITS-1:0] password;
		logic [LEN_BITS-1:0] length;
	} cpl_nv_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} cpl_byte_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_DATA = 4'h2,
		ST_CRC = 4'h4,
		ST_EXEC = 4'h8
	} cpl_state_t;

	// one byte of the block checksum, msb first
	function automatic logic [15:0] cpl_crc16_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		logic fb;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			fb = r[15] ^ d[i];
			r = {r[14:0], 1'b0};
			if (fb) begin
				r = r ^ CRC_POLY;
			end
		end
		return r;
	endfunction : cpl_crc16_byte
endpackage : cpl_pkg

//--- hdl/cpl_lock.sv
// Purpose: password lock logic of a removable flash card
// Assumes: one clock, data block bytes arrive in order from the card receiver
// Notes: password image is loaded from and written back to a non-volatile store
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module cpl_lock
	import cpl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [AXI_AW-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [AXI_AW-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// command gate
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_class,
	output logic cmd_allowed,
	output logic data_access_ok,
	input wire logic lock_cmd,
	output logic lock_cmd_accept,
	// data block stream
	input wire cpl_byte_t blk_in,
	output logic crc_status_ok,
	output logic crc_status_bad,
	// non-volatile image
	input wire cpl_nv_t nv_in,
	output cpl_nv_t nv_out,
	output logic nv_write,
	output logic erase_all,
	output logic locked
);

	////////////////////////////////////////////////////////////////////////////
	// registers and state

	cpl_state_t state;
	logic init_done;
	logic [7:0] password_store [PW_BYTES];
	logic [LEN_BITS-1:0] password_length;
	logic [7:0] rx_buf [RX_BYTES];
	logic [BLKLEN_W-1:0] cnt;
	logic [15:0] crc_acc;
	logic [15:0] rx_crc;
	logic crc_phase;
	logic lock_op_failed_error;
	logic [1:0] ctrl;
	logic [BLKLEN_W-1:0] blk_len;

	// address decode shared by read and write paths
	function automatic logic [3:0] reg_sel(input logic [AXI_AW-1:0] a);
		logic [3:0] s;
		s = 4'h0;
		s[0] = (a == OFF_STATUS);
		s[1] = (a == OFF_CTRL);
		s[2] = (a == OFF_BLKLEN);
		s[3] = (a == OFF_PWLEN);
		return s;
	endfunction : reg_sel

	////////////////////////////////////////////////////////////////////////////
	// command gate

	// only basic and lock classes pass while locked
	assign cmd_allowed = cmd_valid & (~locked | (cmd_class == CLASS_BASIC) | (cmd_class == CLASS_LOCK));
	assign data_access_ok = ~locked;
	// selected card in transfer state, idle engine
	assign lock_cmd_accept = lock_cmd & init_done & (state == ST_IDLE) & ctrl[CTRL_SEL_BIT] & ctrl[CTRL_TRAN_BIT];

	////////////////////////////////////////////////////////////////////////////
	// data block decode
	// the buffer is zeroed at each accepted command, so a short block
	// reads zero beyond its last byte instead of bytes of the previous one

	wire [7:0] mode = rx_buf[0];
	wire [7:0] plen = rx_buf[1];
	wire [LEN_BITS-1:0] len_c = (password_length > PW_BYTES_LEN) ? PW_BYTES_LEN : password_length;
	wire [LEN_BITS-1:0] new_len = plen - password_length;
	wire [PW_BYTES-1:0] byte_eq;
	logic [7:0] new_pw [PW_BYTES];

	// bytes beyond the stored length always compare equal; the length
	// itself is checked against the length byte separately
	// new bytes start right after the old ones, so their source index
	// moves with the stored length
	// compare supplied old bytes and pick new bytes behind them
	generate
		for (genvar i = 0; i < PW_BYTES; i++) begin : g_pw
			wire [5:0] src = 6'(i + 2) + len_c[5:0];
			assign byte_eq[i] = (8'(i) >= len_c) | (rx_buf[i+2] == password_store[i]);
			assign new_pw[i] = (8'(i) < new_len) ? rx_buf[src] : 8'h00;
			assign nv_out.password[8*i +: 8] = password_store[i];
		end
	endgenerate
	assign nv_out.length = password_length;

	// a block longer than the buffer can never pass, which also keeps
	// the byte index of the buffer in range
	// length byte must fit inside the block
	wire size_ok = ({4'h0, plen} + HDR_BYTES_LEN <= blk_len) & (blk_len <= RX_BYTES_LEN);
	wire old_match = &byte_eq;
	wire exact_match = size_ok & old_match & (plen == password_length);
	wire set_ok = size_ok & old_match & (plen > password_length) & (new_len <= PW_BYTES_LEN);
	wire has_pw = (password_length != LEN_RST);

	wire m_erase = mode[MODE_ERASE_BIT];
	wire m_clr = mode[MODE_CLR_BIT];
	wire m_set = mode[MODE_SET_BIT];
	wire m_lock = mode[MODE_LOCK_BIT];

	// the mode bits are tested in a fixed order, so a block with several
	// bits set takes one action, or set and lock together; lock with clear is
	// treated as a plain clear
	// one decision per executed block, erase first
	wire do_erase = m_erase & (mode == MODE_ERASE_ONLY) & (blk_len == ERASE_BLK_LEN) & locked;
	wire do_clear = ~m_erase & m_clr & exact_match;
	wire do_set = ~m_erase & ~m_clr & m_set & set_ok;
	wire do_lock = ~m_erase & ~m_clr & ~m_set & m_lock & ~locked & has_pw & exact_match;
	wire do_unlock = ~m_erase & ~m_clr & ~m_set & ~m_lock & locked & exact_match;
	wire op_ok = do_erase | do_clear | do_set | do_lock | do_unlock;
	wire exec = (state == ST_EXEC);
	wire op_fail = exec & ~op_ok;

	////////////////////////////////////////////////////////////////////////////
	// block receive engine

	wire byte_in = blk_in.valid;
	wire last_payload = (cnt == blk_len - 12'h001);
	wire [15:0] rx_crc_full = {rx_crc[7:0], blk_in.data};
	wire crc_good = (rx_crc_full == crc_acc);

	// crc bytes arrive msb byte first; the first is parked in rx_crc and
	// the pair is compared with the running sum when the second lands
	// a bad block goes straight back to idle and never reaches exec
	// state of the command data block transfer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			cnt <= 12'h000;
			crc_acc <= CRC_INIT;
			rx_crc <= 16'h0000;
			crc_phase <= 1'b0;
			crc_status_ok <= 1'b0;
			crc_status_bad <= 1'b0;
		end else begin
			crc_status_ok <= 1'b0;
			crc_status_bad <= 1'b0;
			case (state)
				ST_IDLE: begin
					cnt <= 12'h000;
					crc_acc <= CRC_INIT;
					crc_phase <= 1'b0;
					if (lock_cmd_accept) begin
						state <= (blk_len == 12'h000) ? ST_CRC : ST_DATA;
					end
				end
				ST_DATA: begin
					if (byte_in) begin
						crc_acc <= cpl_crc16_byte(crc_acc, blk_in.data);
						cnt <= cnt + 12'h001;
						if (last_payload) begin
							state <= ST_CRC;
						end
					end
				end
				ST_CRC: begin
					if (byte_in) begin
						rx_crc <= rx_crc_full;
						crc_phase <= 1'b1;
						if (crc_phase) begin
							crc_status_ok <= crc_good;
							crc_status_bad <= ~crc_good;
							state <= crc_good ? ST_EXEC : ST_IDLE;
						end
					end
				end
				ST_EXEC: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// no reset here: contents only matter after an accepted command,
	// which clears the whole buffer first
	// payload capture, cleared at each new command
	always_ff @(posedge aclk) begin
		for (int i = 0; i < RX_BYTES; i++) begin
			if (lock_cmd_accept) begin
				rx_buf[i] <= 8'h00;
			end else if (state == ST_DATA && byte_in && cnt == BLKLEN_W'(i)) begin
				rx_buf[i] <= blk_in.data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// password store and lock condition

	// locked starts high so no data access slips through in the cycle
	// before the stored length is known
	// nv_write asks the outside store to take nv_out; the image here
	// is the working copy until the next power-up
	// image loaded once after reset, updated by executed blocks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_done <= 1'b0;
			locked <= 1'b1;
			password_length <= LEN_RST;
			nv_write <= 1'b0;
			erase_all <= 1'b0;
			for (int i = 0; i < PW_BYTES; i++) begin
				password_store[i] <= 8'h00;
			end
		end else begin
			nv_write <= 1'b0;
			erase_all <= 1'b0;
			if (!init_done) begin
				init_done <= 1'b1;
				password_length <= nv_in.length;
				locked <= (nv_in.length != LEN_RST);
				for (int i = 0; i < PW_BYTES; i++) begin
					password_store[i] <= nv_in.password[8*i +: 8];
				end
			end else if (exec) begin
				if (do_erase | do_clear) begin
					password_length <= LEN_RST;
					nv_write <= 1'b1;
					for (int i = 0; i < PW_BYTES; i++) begin
						password_store[i] <= 8'h00;
					end
				end
				if (do_set) begin
					password_length <= new_len;
					nv_write <= 1'b1;
					for (int i = 0; i < PW_BYTES; i++) begin
						password_store[i] <= new_pw[i];
					end
				end
				if (do_erase) begin
					erase_all <= 1'b1;
					locked <= 1'b0;
				end
				if ((do_set & m_lock) | do_lock) begin
					locked <= 1'b1;
				end
				if (do_unlock) begin
					locked <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave

	wire wr_go = awvalid & wvalid & ~bvalid;
	wire rd_go = arvalid & ~rvalid;
	wire [3:0] wsel = reg_sel(awaddr);
	wire [3:0] rsel = reg_sel(araddr);
	wire status_read = rd_go & rsel[0];
	wire [31:0] status_word = {29'h0, (state != ST_IDLE), lock_op_failed_error, locked};
	wire [31:0] rd_word = rsel[0] ? status_word :
		rsel[1] ? {30'h0, ctrl} :
		rsel[2] ? {20'h0, blk_len} :
		rsel[3] ? {24'h0, password_length} : 32'h0000_0000;

	assign awready = wr_go;
	assign wready = wr_go;
	assign arready = rd_go;

	// address and data are only taken together, and not while an
	// earlier response still waits for bready
	// write response and writable registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			ctrl <= CTRL_RST;
			blk_len <= BLKLEN_RST;
		end else begin
			if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp <= (|wsel) ? RESP_OKAY : RESP_SLVERR;
				if (wsel[1] && wstrb[0]) begin
					ctrl <= wdata[1:0];
				end
				if (wsel[2] && wstrb[0]) begin
					blk_len[7:0] <= wdata[7:0];
				end
				if (wsel[2] && wstrb[1]) begin
					blk_len[11:8] <= wdata[11:8];
				end
			end
		end
	end

	// read data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= 32'h0000_0000;
		end else begin
			if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
			if (rd_go) begin
				rvalid <= 1'b1;
				rdata <= rd_word;
				rresp <= (|rsel) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// a failure in the same cycle as a status read must not be lost:
	// the read shows the old value and the flag stays set for the next
	// failure flag, a new failure wins over the read clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_op_failed_error <= 1'b0;
		end else if (op_fail) begin
			lock_op_failed_error <= 1'b1;
		end else if (status_read) begin
			lock_op_failed_error <= 1'b0;
		end
	end

endmodule : cpl_lock

//--- verif/cpl_lock_properties.sv
// Purpose: port checks of the password lock
// Assumes: single aclk domain
// Notes: bound into every cpl_lock
`timescale 1ns/1ps
module cpl_lock_properties
	import cpl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_class,
	input wire logic cmd_allowed,
	input wire logic data_access_ok,
	input wire logic lock_cmd,
	input wire logic lock_cmd_accept,
	input wire logic crc_status_ok,
	input wire logic crc_status_bad,
	input wire cpl_nv_t nv_in,
	input wire cpl_nv_t nv_out,
	input wire logic nv_write,
	input wire logic erase_all,
	input wire logic locked
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////
	// command taken, then the block verdict
	sequence s_taken;
		lock_cmd_accept;
	endsequence
	sequence s_verdict;
		##[3:40] (crc_status_ok || crc_status_bad);
	endsequence
	a_class_gate: assert property (cmd_allowed == (cmd_valid && (!locked || cmd_class == 4'h0 || cmd_class == 4'h7)))
		else $error("class gate wrong");
	a_data_gate: assert property (data_access_ok == !locked)
		else $error("data access wrong");
	a_accept_gate: assert property (lock_cmd_accept |-> lock_cmd && !$past(lock_cmd_accept))
		else $error("accept without command");
	a_crc_answer: assert property (s_taken |-> s_verdict)
		else $error("no block verdict");
	a_bad_discard: assert property (crc_status_bad |=> (!nv_write && !erase_all && $stable(locked)) [*2])
		else $error("bad block acted on");
	a_erase_clean: assert property (erase_all |-> !locked && nv_out.length == 8'h00)
		else $error("erase left password");
	a_erase_locked: assert property (erase_all |-> $past(locked))
		else $error("erase while unlocked");
	a_power_lock: assert property ($rose(aresetn) |=> locked == (nv_in.length != 8'h00))
		else $error("power-up lock wrong");
	a_nv_pulse: assert property (nv_write |=> !nv_write)
		else $error("store pulse too long");
endmodule : cpl_lock_properties
bind cpl_lock cpl_lock_properties u_props (.aclk(aclk), .aresetn(aresetn), .cmd_valid(cmd_valid),
	.cmd_class(cmd_class), .cmd_allowed(cmd_allowed), .data_access_ok(data_access_ok), .lock_cmd(lock_cmd),
	.lock_cmd_accept(lock_cmd_accept), .crc_status_ok(crc_status_ok), .crc_status_bad(crc_status_bad),
	.nv_in(nv_in), .nv_out(nv_out), .nv_write(nv_write), .erase_all(erase_all), .locked(locked));

//--- verif/cpl_host_model.sv
// Purpose: host side that sends lock command blocks
// Assumes: bench has set block length and card state
// Notes: idle data toggles so stale bytes never look valid
`timescale 1ns/1ps
module cpl_host_model
	import cpl_pkg::*;
(
	input wire logic aclk,
	output logic lock_cmd,
	output cpl_byte_t blk_in,
	input wire logic crc_status_ok,
	input wire logic crc_status_bad
);
	initial begin
		lock_cmd = 1'b0;
		blk_in = '0;
	end
	////////////////////////////////////////////////////////////
	// command pulse, payload, crc msb byte first, then verdict
	task automatic send(input logic [7:0] q[$], input logic spoil, output logic [1:0] res);
		logic [15:0] c;
		c = 16'h0000;
		res = 2'b00;
		@(posedge aclk);
		lock_cmd <= 1'b1;
		for (int i = 0; i < q.size(); i++) begin
			for (int b = 7; b >= 0; b--) begin
				c = {c[14:0], 1'b0} ^ ((c[15] ^ q[i][b]) ? 16'h1021 : 16'h0000);
			end
		end
		if (spoil) begin
			c = ~c;
		end
		q.push_back(c[15:8]);
		q.push_back(c[7:0]);
		foreach (q[i]) begin
			@(posedge aclk);
			lock_cmd <= 1'b0;
			blk_in <= {1'b1, q[i]};
		end
		repeat (3) begin
			@(posedge aclk);
			blk_in <= {1'b0, ~blk_in.data};
			#1;
			res = res | {crc_status_bad, crc_status_ok};
		end
	endtask : send
endmodule : cpl_host_model

//--- verif/tb.sv
// Purpose: self-checking bench of the password lock
// Assumes: model image of the store is fed back at each power-up
// Notes: command class is randomised every cycle
`timescale 1ns/1ps
module tb
	import cpl_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic cmd_valid = 1'b0;
	logic [3:0] cmd_class = 4'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	cpl_nv_t nv_in = '0;
	cpl_byte_t blk_in;
	logic lock_cmd;
	wire logic awready, wready, bvalid, arready, rvalid, cmd_allowed, data_access_ok, lock_cmd_accept;
	wire logic crc_status_ok, crc_status_bad, nv_write, erase_all, locked;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire cpl_nv_t nv_out;
	logic [31:0] rd_cap;
	logic [1:0] rs_cap;
	logic [7:0] pw[$];
	logic [7:0] p[$];
	logic [7:0] n3[$];
	logic m_lock;
	int fails = 0;
	int comparisons = 0;
	int seed = 82;
	int nv_cnt = 0;
	int er_cnt = 0;
	cpl_lock dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .cmd_valid(cmd_valid),
		.cmd_class(cmd_class), .cmd_allowed(cmd_allowed), .data_access_ok(data_access_ok), .lock_cmd(lock_cmd),
		.lock_cmd_accept(lock_cmd_accept), .blk_in(blk_in), .crc_status_ok(crc_status_ok),
		.crc_status_bad(crc_status_bad), .nv_in(nv_in), .nv_out(nv_out), .nv_write(nv_write),
		.erase_all(erase_all), .locked(locked));
	cpl_host_model host (.aclk(aclk), .lock_cmd(lock_cmd), .blk_in(blk_in), .crc_status_ok(crc_status_ok),
		.crc_status_bad(crc_status_bad));
	initial begin
		forever #4 aclk = ~aclk;
	end
	// random command traffic for the class gate
	always @(posedge aclk) begin
		cmd_valid <= 1'($random(seed));
		cmd_class <= 4'($random(seed));
	end
	// count store and erase pulses, sampled as they stand
	always @(posedge aclk) begin
		nv_cnt <= nv_cnt + int'(nv_write);
		er_cnt <= er_cnt + int'(erase_all);
	end
	////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask : chk
	function automatic logic sig(input int k);
		return k == 0 ? awready : k == 1 ? bvalid : k == 2 ? arready : rvalid;
	endfunction : sig
	// bounded wait for one handshake, ends on its taking edge
	task automatic hs(input int k);
		int n;
		n = 0;
		#1;
		while (sig(k) !== 1'b1 && n < 100) begin
			@(posedge aclk);
			#1;
			n++;
		end
		if (sig(k) !== 1'b1) begin
			chk("handshake", 32'h1, 32'h0);
			complete_run();
		end
		rd_cap = rdata;
		rs_cap = k == 1 ? bresp : rresp;
		@(posedge aclk);
	endtask : hs
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		hs(0);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		hs(1);
		bready <= 1'b0;
		chk("write resp", {30'h0, RESP_OKAY}, {30'h0, rs_cap});
	endtask : axw
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		hs(2);
		arvalid <= 1'b0;
		hs(3);
		rready <= 1'b0;
	endtask : axr
	// power cycle, the store image comes from the model
	task automatic rst();
		@(posedge aclk);
		aresetn <= 1'b0;
		nv_in.length <= 8'(pw.size());
		for (int i = 0; i < PW_BYTES; i++) begin
			nv_in.password[8*i +: 8] <= i < pw.size() ? pw[i] : 8'h00;
		end
		m_lock = pw.size() != 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		#1;
		chk("power-up lock", {31'h0, m_lock}, {31'h0, locked});
		axw(OFF_CTRL, 32'h3);
	endtask : rst
	// reference decision on one accepted block
	task automatic model(input logic [7:0] q[$], output logic f);
		logic [7:0] m;
		int n;
		logic pm;
		logic eq;
		m = q[0];
		n = pw.size();
		pm = q.size() >= n + 2;
		for (int i = 0; i < n && pm; i++) begin
			pm = q[i+2] == pw[i];
		end
		eq = pm && q[1] == n;
		f = 1'b0;
		if (m[3]) begin
			f = !(m == MODE_ERASE_ONLY && q.size() == 1 && m_lock);
			if (!f) begin
				pw = {};
				m_lock = 1'b0;
			end
		end else if (m[1]) begin
			f = !eq;
			if (!f) begin
				pw = {};
			end
		end else if (m[0]) begin
			f = !(pm && q[1] > n && q[1] <= n + 16 && q.size() == q[1] + 2);
			if (!f) begin
				pw = q[n+2:$];
				m_lock = m_lock | m[2];
			end
		end else if (m[2]) begin
			f = m_lock || n == 0 || !eq;
			m_lock = m_lock | !f;
		end else begin
			f = !m_lock || !eq;
			m_lock = m_lock & f;
		end
	endtask : model
	task automatic op(input logic [7:0] q[$], input logic spoil);
		logic [1:0] res;
		logic f;
		logic wr;
		logic ga;
		int n0;
		int e0;
		axw(OFF_BLKLEN, 32'(q.size()));
		n0 = nv_cnt;
		e0 = er_cnt;
		host.send(q, spoil, res);
		chk("crc verdict", spoil ? 32'h2 : 32'h1, {30'h0, res});
		f = 1'b0;
		if (!spoil) begin
			model(q, f);
		end
		wr = !spoil && !f && (q[0][3] || q[0][1] || q[0][0]);
		chk("store writes", {31'h0, wr}, 32'(nv_cnt - n0));
		chk("erase pulses", {31'h0, !spoil && !f && q[0][3]}, 32'(er_cnt - e0));
		axr(OFF_STATUS);
		chk("status", {30'h0, f, m_lock}, rd_cap & 32'h7);
		axr(OFF_PWLEN);
		chk("stored length", 32'(pw.size()), rd_cap);
		chk("image length", 32'(pw.size()), {24'h0, nv_out.length});
		for (int i = 0; i < PW_BYTES; i++) begin
			chk("image byte", i < pw.size() ? {24'h0, pw[i]} : 32'h0, {24'h0, nv_out.password[8*i +: 8]});
		end
		#1;
		chk("data access", {31'h0, !m_lock}, {31'h0, data_access_ok});
		ga = cmd_valid && (!m_lock || cmd_class == CLASS_BASIC || cmd_class == CLASS_LOCK);
		chk("class gate", {31'h0, ga}, {31'h0, cmd_allowed});
	endtask : op
	////////////////////////////////////////////////////////////
	initial begin
		rst();
		axr(8'h40);
		chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs_cap});
		op({8'h04, 8'h00}, 1'b0);
		axr(OFF_STATUS);
		chk("fail cleared", 32'h0, rd_cap & 32'h2);
		repeat (4) p.push_back(8'($random(seed)));
		repeat (3) n3.push_back(8'($random(seed)));
		op({8'h01, 8'h04, p}, 1'b0);
		op({8'h00, 8'h04, p}, 1'b0);
		op({8'h08}, 1'b0);
		op({8'h04, 8'h04, ~p[0], p[1:3]}, 1'b0);
		op({8'h04, 8'h04, p}, 1'b0);
		op({8'h00, 8'h04, p}, 1'b1);
		op({8'h00, 8'h04, p}, 1'b0);
		op({8'h05, 8'h07, p, n3}, 1'b0);
		op({8'h09}, 1'b0);
		rst();
		op({8'h08}, 1'b0);
		op({8'h01, 8'h02, n3[0:1]}, 1'b0);
		op({8'h06, 8'h02, n3[0:1]}, 1'b0);
		complete_run();
	end
endmodule : tb
